// ### include/jib_pkg.sv
// package for the boundary-scan instruction and bypass logic
package jib_pkg;

    localparam int IR_WIDTH   = 3;
    localparam int BSR_LENGTH = 196;

    typedef enum logic [2:0] {
        JIB_EXTEST  = 3'h0,
        JIB_SAMPLE  = 3'h1,
        JIB_HIZ     = 3'h4,
        JIB_CLAMP   = 3'h5
    } jib_instr_t;

    localparam logic [2:0] IR_RESET_VAL   = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h5;
    localparam logic       BYP_CAPTURE    = 1'h0;

    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SDRS = 4'h2, CDR = 4'h3,
        SDR = 4'h4, E1DR = 4'h5, PDR = 4'h6, E2DR = 4'h7,
        UDR = 4'h8, SIRS = 4'h9, CIR = 4'ha, SIR = 4'hb,
        E1IR = 4'hc, PIR = 4'hd, E2IR = 4'he, UIR = 4'hf
    } jib_tap_t;

    typedef struct packed {
        logic extest;
        logic sample;
        logic bypass;
        logic hiz;
        logic clamp;
    } jib_dec_t;

endpackage : jib_pkg

// ### src/jib_tap.sv
// tap controller, instruction register, bypass and boundary register
`timescale 1ns/100ps

// Operation
// - three-bit shift stage plus update latches
// - decode extest, sample, bypass, float codes
// - reset state latches all ones
// - capture-ir loads clamp code
// - extest selects boundary, holds system reset
// - boundary drives outputs, captures inputs
// - one control cell enables pin group
// - preload fills boundary before extest
// - live snapshot sampling of output cells not supported
// - bypass routes tdi through one bit
// - bypass captures zero in capture-dr
// - clamp drives pins from boundary register
// - float instruction disables all drivers
// - float pin during reset floats outputs
// - power-on reset holds tap in reset
// - low-power stop only in reset state
// - test clock never blocked in stop
// - five tms highs force reset state
// - tms held high keeps reset state
module jib_tap #(
    parameter int N_OUT = 16,
    parameter int N_IN  = 8,
    parameter int N_GRP = 4
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic             float_all_outputs_pin,
    input  wire logic             low_power_stop_instruction,
    output logic                  stop_granted,
    output logic                  sys_reset_hold,
    input  wire logic [N_OUT-1:0] sys_out,
    input  wire logic [N_GRP-1:0] sys_oe,
    input  wire logic [N_IN-1:0]  pin_in,
    output logic [N_OUT-1:0]      pin_out,
    output logic [N_OUT-1:0]      pin_oe
);

    ////////////////////////////////////////////////////////////////
    // sizes of the pin groups and boundary register
    localparam int GSZ = N_OUT / N_GRP;
    localparam int BSR = N_IN + N_OUT + N_GRP;

    ////////////////////////////////////////////////////////////////
    // tap state machine on tck, reset by power-on reset
    jib_pkg::jib_tap_t st_q;
    jib_pkg::jib_tap_t st_d;

    always_comb begin
        case (st_q)
            jib_pkg::TLR: begin
                if (tms) begin
                    st_d = jib_pkg::TLR;
                end else begin
                    st_d = jib_pkg::RTI;
                end
            end
            jib_pkg::RTI: begin
                if (tms) begin
                    st_d = jib_pkg::SDRS;
                end else begin
                    st_d = jib_pkg::RTI;
                end
            end
            jib_pkg::SDRS: begin
                if (tms) begin
                    st_d = jib_pkg::SIRS;
                end else begin
                    st_d = jib_pkg::CDR;
                end
            end
            jib_pkg::CDR: begin
                if (tms) begin
                    st_d = jib_pkg::E1DR;
                end else begin
                    st_d = jib_pkg::SDR;
                end
            end
            jib_pkg::SDR: begin
                if (tms) begin
                    st_d = jib_pkg::E1DR;
                end else begin
                    st_d = jib_pkg::SDR;
                end
            end
            jib_pkg::E1DR: begin
                if (tms) begin
                    st_d = jib_pkg::UDR;
                end else begin
                    st_d = jib_pkg::PDR;
                end
            end
            jib_pkg::PDR: begin
                if (tms) begin
                    st_d = jib_pkg::E2DR;
                end else begin
                    st_d = jib_pkg::PDR;
                end
            end
            jib_pkg::E2DR: begin
                if (tms) begin
                    st_d = jib_pkg::UDR;
                end else begin
                    st_d = jib_pkg::SDR;
                end
            end
            jib_pkg::UDR: begin
                if (tms) begin
                    st_d = jib_pkg::SDRS;
                end else begin
                    st_d = jib_pkg::RTI;
                end
            end
            jib_pkg::SIRS: begin
                if (tms) begin
                    st_d = jib_pkg::TLR;
                end else begin
                    st_d = jib_pkg::CIR;
                end
            end
            jib_pkg::CIR: begin
                if (tms) begin
                    st_d = jib_pkg::E1IR;
                end else begin
                    st_d = jib_pkg::SIR;
                end
            end
            jib_pkg::SIR: begin
                if (tms) begin
                    st_d = jib_pkg::E1IR;
                end else begin
                    st_d = jib_pkg::SIR;
                end
            end
            jib_pkg::E1IR: begin
                if (tms) begin
                    st_d = jib_pkg::UIR;
                end else begin
                    st_d = jib_pkg::PIR;
                end
            end
            jib_pkg::PIR: begin
                if (tms) begin
                    st_d = jib_pkg::E2IR;
                end else begin
                    st_d = jib_pkg::PIR;
                end
            end
            jib_pkg::E2IR: begin
                if (tms) begin
                    st_d = jib_pkg::UIR;
                end else begin
                    st_d = jib_pkg::SIR;
                end
            end
            jib_pkg::UIR: begin
                if (tms) begin
                    st_d = jib_pkg::SDRS;
                end else begin
                    st_d = jib_pkg::RTI;
                end
            end
            default: begin
                st_d = jib_pkg::TLR;
            end
        endcase
    end

    // tck free-running; never gated by stop
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) st_q <= jib_pkg::TLR;
        else       st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////
    // state decode
    wire in_tlr = (st_q == jib_pkg::TLR);
    wire in_cir = (st_q == jib_pkg::CIR);
    wire in_sir = (st_q == jib_pkg::SIR);
    wire in_uir = (st_q == jib_pkg::UIR);
    wire in_cdr = (st_q == jib_pkg::CDR);
    wire in_sdr = (st_q == jib_pkg::SDR);
    wire in_udr = (st_q == jib_pkg::UDR);

    ////////////////////////////////////////////////////////////////
    // pins and float pin synchronised into tck domain
    logic [1:0]       flt_q;
    logic [N_IN-1:0]  pin_in_m_q;
    logic [N_IN-1:0]  pin_in_s_q;
    logic [N_OUT-1:0] sys_out_m_q;
    logic [N_OUT-1:0] sys_out_s_q;
    logic [N_GRP-1:0] sys_oe_m_q;
    logic [N_GRP-1:0] sys_oe_s_q;

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            flt_q       <= 2'h0;
            pin_in_m_q  <= '0;
            pin_in_s_q  <= '0;
            sys_out_m_q <= '0;
            sys_out_s_q <= '0;
            sys_oe_m_q  <= '0;
            sys_oe_s_q  <= '0;
        end else begin
            flt_q       <= {flt_q[0], float_all_outputs_pin};
            pin_in_m_q  <= pin_in;
            pin_in_s_q  <= pin_in_m_q;
            sys_out_m_q <= sys_out;
            sys_out_s_q <= sys_out_m_q;
            sys_oe_m_q  <= sys_oe;
            sys_oe_s_q  <= sys_oe_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // instruction register
    logic [2:0] ir_sh_q;
    logic [2:0] ir_q;
    wire  [2:0] ir_shift_d = {tdi, ir_sh_q[2:1]};

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn)       ir_sh_q <= jib_pkg::IR_RESET_VAL;
        else if (in_cir) ir_sh_q <= jib_pkg::IR_CAPTURE_VAL;
        else if (in_sir) ir_sh_q <= ir_shift_d;
    end

    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn)       ir_q <= jib_pkg::IR_RESET_VAL;
        else if (in_tlr) ir_q <= jib_pkg::IR_RESET_VAL;
        else if (in_uir) ir_q <= ir_sh_q;
    end

    ////////////////////////////////////////////////////////////////
    // instruction decode
    jib_pkg::jib_dec_t dec;
    assign dec.extest = (ir_q == jib_pkg::JIB_EXTEST);
    assign dec.sample = (ir_q == jib_pkg::JIB_SAMPLE);
    assign dec.bypass = ir_q[1];
    assign dec.hiz    = (ir_q == jib_pkg::JIB_HIZ);
    assign dec.clamp  = (ir_q == jib_pkg::JIB_CLAMP);

    wire bsr_sel    = dec.extest | dec.sample;
    wire test_drive = dec.extest | dec.clamp;

    ////////////////////////////////////////////////////////////////
    // bypass register
    logic byp_q;

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn)       byp_q <= 1'h0;
        else if (in_cdr) byp_q <= jib_pkg::BYP_CAPTURE;
        else if (in_sdr) byp_q <= tdi;
    end

    ////////////////////////////////////////////////////////////////
    // boundary register
    logic [BSR-1:0] bsr_sh_q;
    logic [BSR-1:0] bsr_up_q;

    // input cells capture pins; snapshot of outputs not supported
    wire [BSR-1:0] bsr_cap     = {bsr_sh_q[BSR-1:N_IN], pin_in_s_q};
    wire [BSR-1:0] bsr_shift_d = {tdi, bsr_sh_q[BSR-1:1]};
    wire           bsr_cap_en  = bsr_sel & in_cdr;
    wire           bsr_sh_en   = bsr_sel & in_sdr;
    wire           bsr_upd_en  = bsr_sel & in_udr;

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn)           bsr_sh_q <= '0;
        else if (bsr_cap_en) bsr_sh_q <= bsr_cap;
        else if (bsr_sh_en)  bsr_sh_q <= bsr_shift_d;
    end

    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn)           bsr_up_q <= '0;
        else if (bsr_upd_en) bsr_up_q <= bsr_sh_q;
    end

    ////////////////////////////////////////////////////////////////
    // tdo and its enable on falling tck
    wire dr_src  = bsr_sel ? bsr_sh_q[0] : byp_q;
    wire tdo_src = in_sir ? ir_sh_q[0] : dr_src;

    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'h0;
        end else begin
            tdo <= tdo_src;
        end
    end

    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            tdo_oe <= 1'h0;
        end else begin
            tdo_oe <= in_sir | in_sdr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin muxing; boundary out cells then group control cells
    wire [N_OUT-1:0] bsr_out   = bsr_up_q[N_IN +: N_OUT];
    wire [N_GRP-1:0] bsr_ctl   = bsr_up_q[N_IN+N_OUT +: N_GRP];
    wire             float_all = dec.hiz | flt_q[1];

    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : g_pin
            wire oe_src  = test_drive ? bsr_ctl[g / GSZ] : sys_oe_s_q[g / GSZ];
            wire out_src = test_drive ? bsr_out[g] : sys_out_s_q[g];

            always_ff @(posedge tck or negedge rstn) begin
                if (!rstn) begin
                    pin_out[g] <= 1'h0;
                    pin_oe[g]  <= 1'h0;
                end else begin
                    pin_out[g] <= out_src;
                    pin_oe[g]  <= oe_src & ~float_all;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // crossings into system clock domain, two flip-flops each
    wire ext_tck = dec.extest;
    wire tlr_tck = in_tlr;
    logic [1:0] ext_sync_q;
    logic [1:0] tlr_sync_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync_q <= 2'h0;
            tlr_sync_q <= 2'h3;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_tck};
            tlr_sync_q <= {tlr_sync_q[0], tlr_tck};
        end
    end

    ////////////////////////////////////////////////////////////////
    // system reset hold and stop grant
    wire stop_ok = low_power_stop_instruction & tlr_sync_q[1];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reset_hold <= 1'h1;
        end else begin
            sys_reset_hold <= ext_sync_q[1];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_granted <= 1'h0;
        end else begin
            stop_granted <= stop_ok;
        end
    end

endmodule : jib_tap

// ### bench/jib_tap_sva.sv
// assertions on the tap logic ports
`timescale 1ns/100ps
module jib_tap_sva #(
    parameter int N_OUT = 16
) (
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire logic             float_all_outputs_pin,
    input wire logic             low_power_stop_instruction,
    input wire logic             stop_granted,
    input wire logic             sys_reset_hold,
    input wire logic [N_OUT-1:0] pin_out,
    input wire logic [N_OUT-1:0] pin_oe
);
    a_tdo_on_fall: assert property (@(posedge clk) disable iff (!rstn)
        tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe)) else $error("tdo moved, tck high");
    a_pins_on_rise: assert property (@(posedge clk) disable iff (!rstn)
        !tck && !$past(tck) |-> $stable(pin_out) && $stable(pin_oe)) else $error("pin moved");
    a_stop_in_reset: assert property (@(posedge clk) disable iff (!rstn)
        stop_granted |-> !tdo_oe) else $error("stop while shifting");
    a_stop_needs_req: assert property (@(posedge clk) disable iff (!rstn)
        $rose(stop_granted) |-> $past(low_power_stop_instruction)) else $error("stop unasked");
    a_stop_drop: assert property (@(posedge clk) disable iff (!rstn)
        stop_granted && !low_power_stop_instruction |=> !stop_granted) else $error("stop kept");
    a_float_all: assert property (@(posedge tck) disable iff (!rstn)
        float_all_outputs_pin [*4] |=> pin_oe == '0) else $error("outputs not floated");
    a_tms_to_reset: assert property (@(posedge tck) disable iff (!rstn)
        tms [*5] |-> !tdo_oe) else $error("not in reset state");
    a_tms_hold_reset: assert property (@(posedge tck) disable iff (!rstn)
        tms [*6] |-> !sys_reset_hold) else $error("left reset state");
endmodule : jib_tap_sva
bind jib_tap jib_tap_sva #(.N_OUT(N_OUT)) u_sva (.*);

// ### bench/jib_tester.sv
// boundary-scan tester model
`timescale 1ns/100ps
module jib_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end
    // own clock, tdo taken at own rise only
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80 tck = 1'h1;
        o = tdo;
        #80 tck = 1'h0;
    endtask : step
    task automatic idle();
        logic o;
        repeat (5) step(1'h1, 1'h0, o);
        step(1'h0, 1'h1, o);
    endtask : idle
    // scan from run-test/idle back to it, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        step(1'h1, 1'h1, o);
        if (ir) step(1'h1, 1'h0, o);
        step(1'h0, 1'h1, o);
        step(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'h1, ~din[n-1], o);
        step(1'h0, din[0], o);
    endtask : scan
endmodule : jib_tester

// ### bench/test_jib_tap.sv
// testbench for the tap logic
`timescale 1ns/100ps
module test_jib_tap;
    localparam int NO = 4;
    localparam int NI = 2;
    localparam int NG = 2;
    localparam int L  = NI + NO + NG;
    logic          clk, rstn, tck, tms, tdi, tdo, tdo_oe, o;
    logic          fpin, sreq, sgnt, hold;
    logic [NO-1:0] sys_out, pin_out, pin_oe;
    logic [NG-1:0] sys_oe;
    logic [NI-1:0] pin_in;
    logic [63:0]   v;
    int            err_total, num_checks;
    jib_tap #(.N_OUT(NO), .N_IN(NI), .N_GRP(NG)) dut (.clk(clk), .rstn(rstn), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .float_all_outputs_pin(fpin),
        .low_power_stop_instruction(sreq), .stop_granted(sgnt), .sys_reset_hold(hold),
        .sys_out(sys_out), .sys_oe(sys_oe), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    jib_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    task automatic t_ir_bypass();
        tester.idle();
        settle();
        chk("hold", 0, hold);
        tester.scan(1, 3, 3'h7, v);
        chk("ir capture", 3'h5, v[2:0]);
        tester.scan(0, 4, 4'hb, v);
        chk("bypass", 4'h6, v[3:0]);
        $display("ir and bypass done");
    endtask : t_ir_bypass
    task automatic t_extest();
        tester.scan(1, 3, 3'h1, v);
        tester.scan(0, L, {2'h3, 4'ha, 2'h0}, v);
        tester.scan(1, 3, 3'h0, v);
        tester.step(0, 0, o);
        settle();
        chk("ext out", 4'ha, pin_out);
        chk("ext oe", 4'hf, pin_oe);
        chk("ext hold", 1, hold);
        tester.scan(0, L, {2'h1, 4'h5, 2'h0}, v);
        tester.step(0, 0, o);
        chk("capture", 2'h2, v[NI-1:0]);
        chk("group oe", 4'h3, pin_oe);
        $display("extest done");
    endtask : t_extest
    task automatic t_clamp_hiz();
        tester.scan(1, 3, 3'h5, v);
        tester.step(0, 0, o);
        settle();
        chk("clamp out", 4'h5, pin_out);
        chk("clamp hold", 0, hold);
        tester.scan(0, 2, 2'h3, v);
        chk("clamp byp", 2'h2, v[1:0]);
        tester.scan(1, 3, 3'h4, v);
        tester.step(0, 0, o);
        chk("hiz oe", 0, pin_oe);
        tester.scan(0, 2, 2'h3, v);
        chk("hiz byp", 2'h2, v[1:0]);
        $display("clamp and float done");
    endtask : t_clamp_hiz
    task automatic t_float_stop();
        repeat (8) tester.step(1, 0, o);
        chk("sys oe", 4'hf, pin_oe);
        chk("sys out", 4'h9, pin_out);
        fpin = 1'h1;
        repeat (5) tester.step(1, 0, o);
        chk("float oe", 0, pin_oe);
        fpin = 1'h0;
        sreq = 1'h1;
        settle();
        chk("stop", 1, sgnt);
        tester.step(0, 0, o);
        settle();
        chk("no stop", 0, sgnt);
        sreq = 1'h0;
        $display("float and stop done");
    endtask : t_float_stop
    initial begin
        {rstn, fpin, sreq} = 3'h0;
        {sys_out, sys_oe, pin_in} = {4'h9, 2'h3, 2'h2};
        repeat (10) @(posedge clk);
        #1;
        chk("reset hold", 1, hold);
        rstn = 1'h1;
        t_ir_bypass();
        t_extest();
        t_clamp_hiz();
        t_float_stop();
        end_of_test();
    end
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : test_jib_tap
